/* bench/isoops_properties.sv */
/* isoops_properties: port timing checks for isoops_core.
   assumes: bound to isoops_core, one clock, sync reset. */
`timescale 1ns/1ps
module isoops_properties (
  // clock and instruction
  input wire logic clk,
  input wire logic reset,
  input wire logic insn_valid,
  input wire logic [11:0] insn,
  input wire logic [7:0] file_rdata,
  // results
  input wire logic file_we_ff,
  input wire logic [7:0] file_wdata_ff,
  input wire logic [4:0] file_waddr_ff,
  input wire logic [7:0] acc_ff,
  input wire logic zero_ff,
  input wire logic flush_ff,
  input wire logic done_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // a word in the flushed slot counts as nothing
  wire tk = insn_valid & ~flush_ff;
  wire inc = tk & (insn[11:6] == 6'h0F);
  wire orl = tk & (insn[11:8] == 4'hD);
  wire orr = tk & (insn[11:6] == 6'h04);
  a_inc_to_file: assert property (inc && insn[5] |=> file_we_ff && file_waddr_ff == $past(insn[4:0])
    && file_wdata_ff == 8'($past(file_rdata) + 8'h01)) else $error("bad file sum");
  a_inc_to_acc: assert property (inc && !insn[5] |=> !file_we_ff
    && acc_ff == 8'($past(file_rdata) + 8'h01)) else $error("bad acc sum");
  a_skip_flush: assert property (inc |=> flush_ff == ($past(file_rdata) == 8'hFF)
    && $stable(zero_ff)) else $error("bad skip");
  a_flush_once: assert property (flush_ff |=> !flush_ff && !done_ff) else $error("bad slot");
  a_or_literal: assert property (orl |=> acc_ff == ($past(acc_ff) | $past(insn[7:0]))
    && zero_ff == (acc_ff == 8'h00)) else $error("bad literal or");
  a_or_to_file: assert property (orr && insn[5] |=> file_we_ff && $stable(acc_ff)
    && file_wdata_ff == ($past(acc_ff) | $past(file_rdata))) else $error("bad file or");
  a_or_zero: assert property (orr |=> done_ff
    && zero_ff == (($past(acc_ff) | $past(file_rdata)) == 8'h00)) else $error("bad zero");
endmodule
bind isoops_core isoops_properties u_isoops_properties (.clk(clk), .reset(reset), .insn_valid(insn_valid),
  .insn(insn), .file_rdata(file_rdata), .file_we_ff(file_we_ff), .file_wdata_ff(file_wdata_ff),
  .file_waddr_ff(file_waddr_ff), .acc_ff(acc_ff), .zero_ff(zero_ff), .flush_ff(flush_ff), .done_ff(done_ff));

/* bench/tb_top.sv */
/* tb_top: directed tests of isoops_core.
   assumes: the bench plays fetch and the register file. */
`timescale 1ns/1ps
module tb_top;
  logic clk = 0;
  logic reset = 1;
  logic insn_valid = 0;
  logic [11:0] insn = 12'h000;
  logic [7:0] file_rdata = 8'h00;
  logic [4:0] file_addr, file_waddr_ff;
  logic [7:0] file_wdata_ff, acc_ff;
  logic file_we_ff, zero_ff, flush_ff, done_ff;
  int miscompares = 0;
  int checked = 0;
  always #20 clk = ~clk;
  isoops_core u_isoops_core (.clk(clk), .reset(reset), .insn_valid(insn_valid), .insn(insn), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_we_ff(file_we_ff), .file_wdata_ff(file_wdata_ff), .file_waddr_ff(file_waddr_ff),
    .acc_ff(acc_ff), .zero_ff(zero_ff), .flush_ff(flush_ff), .done_ff(done_ff));
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // inputs move 1 ns after the edge, so calls run back to back
  task run(input logic [11:0] w, input logic [7:0] r);
    insn = w;
    file_rdata = r;
    insn_valid = 1;
    @(posedge clk);
    #1;
  endtask
  task do_reset;
    reset = 1;
    insn_valid = 0;
    repeat (2) @(posedge clk);
    #1;
    reset = 0;
  endtask
  task t_inc;
    run(12'h3E3, 8'h41);
    chk({flush_ff, file_we_ff, file_waddr_ff, file_wdata_ff}, {2'h1, 5'h03, 8'h42});
    chk(file_addr, 5'h03);
    run(12'h3C7, 8'h7F);
    chk({file_we_ff, acc_ff}, {1'h0, 8'h80});
  endtask
  // the flushed word would have changed acc
  task t_skip;
    run(12'h3E3, 8'hFF);
    chk({flush_ff, zero_ff, file_wdata_ff}, {2'h2, 8'h00});
    run(12'hD01, 8'h00);
    chk({flush_ff, done_ff, acc_ff}, {2'h0, 8'h80});
  endtask
  task t_or;
    run(12'hD35, 8'h00);
    chk({zero_ff, acc_ff}, {1'h0, 8'hB5});
    run(12'h103, 8'h13);
    chk({file_we_ff, acc_ff}, {1'h0, 8'hB7});
    run(12'h123, 8'h48);
    chk({file_we_ff, acc_ff, file_wdata_ff}, {1'h1, 8'hB7, 8'hFF});
    run(12'h000, 8'h00);
    chk({done_ff, acc_ff}, {1'h0, 8'hB7});
  endtask
  // the ORs cannot clear acc, so a reset brings it back to zero for the flag cases
  task t_zero;
    do_reset;
    run(12'hD00, 8'h00);
    chk({zero_ff, acc_ff}, {1'h1, 8'h00});
    run(12'h105, 8'h00);
    chk({zero_ff, done_ff, acc_ff}, {2'h3, 8'h00});
    run(12'h3C5, 8'h10);
    chk({zero_ff, flush_ff, acc_ff}, {2'h2, 8'h11});
    run(12'hD01, 8'h00);
    chk({zero_ff, done_ff, acc_ff}, {2'h1, 8'h11});
    insn_valid = 0;
  endtask
  task final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    do_reset;
    t_inc;
    t_skip;
    t_or;
    t_zero;
    final_report;
  end
  initial begin
    // the scenarios need under 40 cycles; ten times that means a hang
    repeat (400) @(posedge clk);
    miscompares++;
    final_report;
  end
endmodule

/* pkg/isoops_pkg.sv */
/*
  isoops_pkg: opcode patterns, field positions, reset values and timing for the
  increment-skip and OR instruction decoder.
  assumes: 12-bit instruction words, 8-bit data path, 5-bit file address.
*/
package isoops_pkg;
  localparam int unsigned INSN_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 5;
  // opcode patterns: the word masked by the mask must equal the pattern
  localparam logic [11:0] INC_SKIP_MASK = 12'hFC0;
  localparam logic [11:0] INC_SKIP_PAT = 12'h3C0;
  localparam logic [11:0] OR_REG_MASK = 12'hFC0;
  localparam logic [11:0] OR_REG_PAT = 12'h100;
  localparam logic [11:0] OR_LIT_MASK = 12'hF00;
  localparam logic [11:0] OR_LIT_PAT = 12'hD00;
  // field positions
  localparam int unsigned DEST_BIT = 5;
  localparam int unsigned ADDR_LSB = 0;
  localparam int unsigned LIT_LSB = 0;
  // destination bit encoding
  localparam logic DEST_ACC = 1'h0;
  localparam logic DEST_REG = 1'h1;
  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'h0;
  localparam logic FILE_WE_RESET = 1'h0;
  localparam logic [7:0] FILE_WDATA_RESET = 8'h00;
  localparam logic [4:0] FILE_WADDR_RESET = 5'h00;
  localparam logic FLUSH_RESET = 1'h0;
  localparam logic DONE_RESET = 1'h0;
  // the skip slot: one extra cycle
  localparam int unsigned SKIP_CYCLES = 1;
  typedef enum logic [1:0] {
    ISOOPS_OP_NONE = 2'b00,
    ISOOPS_OP_INC_SKIP = 2'b01,
    ISOOPS_OP_OR_LIT = 2'b10,
    ISOOPS_OP_OR_REG = 2'b11
  } isoops_op_t;
endpackage

/* verilog/isoops_core.sv */
/*
  isoops_core: executes the increment-skip-if-zero, OR-literal and OR-register
  instruction words for a small 8-bit core.
  assumes: the fetch logic presents one instruction per clock with insn_valid;
  the register file answers file_rdata combinationally for file_addr; the core
  honours flush by replacing the already-fetched next word with a no-operation.
*/
// Overview of operation
// RULE1: increment-skip opcode adds one to register
// RULE2: destination bit 0 accumulator, 1 register
// RULE3: zero sum flushes next word, no flags
// RULE4: literal OR into accumulator, zero updated
// RULE5: register OR routed by destination, zero updated
// RULE6: zero set on zero result; single-cycle ORs
`timescale 1ns/1ps
module isoops_core (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // instruction in
  input wire logic insn_valid,
  input wire logic [11:0] insn,
  // file register port
  output logic [4:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic file_we_ff,
  output logic [7:0] file_wdata_ff,
  output logic [4:0] file_waddr_ff,
  // core state
  output logic [7:0] acc_ff,
  output logic zero_ff,
  output logic flush_ff,
  output logic done_ff
);
  // one masked pattern test, shared by every opcode below
  function automatic logic isoops_match(input logic [11:0] w, input logic [11:0] mask, input logic [11:0] pat);
    return ((w & mask) == pat);
  endfunction

  // decoding used for execution only; file_addr comes straight from the word fields
  function automatic isoops_pkg::isoops_op_t isoops_decode(input logic [11:0] w);
    if (isoops_match(w, isoops_pkg::INC_SKIP_MASK, isoops_pkg::INC_SKIP_PAT)) begin
      return isoops_pkg::ISOOPS_OP_INC_SKIP;
    end else if (isoops_match(w, isoops_pkg::OR_LIT_MASK, isoops_pkg::OR_LIT_PAT)) begin
      return isoops_pkg::ISOOPS_OP_OR_LIT;
    end else if (isoops_match(w, isoops_pkg::OR_REG_MASK, isoops_pkg::OR_REG_PAT)) begin
      return isoops_pkg::ISOOPS_OP_OR_REG;
    end else begin
      return isoops_pkg::ISOOPS_OP_NONE;
    end
  endfunction

  // the opcodes fix the word layout, so the package widths must match the ports
  if (isoops_pkg::INSN_W != $bits(insn)) begin : g_check_insn_w
    $error("instruction width does not match the insn port");
  end
  if (isoops_pkg::DATA_W != $bits(acc_ff)) begin : g_check_data_w
    $error("data width does not match the accumulator port");
  end
  if (isoops_pkg::ADDR_W != $bits(file_addr)) begin : g_check_addr_w
    $error("address width does not match the file_addr port");
  end
  // the destination bit must sit above the address field and inside the word
  if (isoops_pkg::ADDR_LSB + isoops_pkg::ADDR_W > isoops_pkg::DEST_BIT) begin : g_check_dest_pos
    $error("destination bit overlaps the address field");
  end
  if (isoops_pkg::DEST_BIT >= isoops_pkg::INSN_W) begin : g_check_dest_range
    $error("destination bit lies outside the word");
  end
  if (isoops_pkg::LIT_LSB + isoops_pkg::DATA_W > isoops_pkg::INSN_W) begin : g_check_lit_range
    $error("literal field lies outside the word");
  end
  // flush_ff covers a single slot; a longer skip would need a counter here
  if (isoops_pkg::SKIP_CYCLES != 1) begin : g_check_skip
    $error("only a one-slot skip is supported");
  end

  isoops_pkg::isoops_op_t op;
  logic dest;
  logic [7:0] lit;
  logic [7:0] sum;
  logic [7:0] or_lit;
  logic [7:0] or_reg;
  logic [7:0] result;
  logic writes_reg;
  logic writes_acc;
  logic sets_zero;
  logic nxt_flush;
  logic [7:0] nxt_acc;
  logic nxt_zero;
  logic nxt_file_we;
  logic [7:0] nxt_file_wdata;
  logic [4:0] nxt_file_waddr;
  logic nxt_done;

  // operand fields
  assign file_addr = insn[isoops_pkg::ADDR_LSB +: isoops_pkg::ADDR_W];
  assign dest = insn[isoops_pkg::DEST_BIT];
  assign lit = insn[isoops_pkg::LIT_LSB +: isoops_pkg::DATA_W];

  // all results form every cycle; the decoder picks one, trading area for a short path
  assign sum = file_rdata + 8'h01; // RULE1
  assign or_lit = acc_ff | lit; // RULE4
  assign or_reg = acc_ff | file_rdata; // RULE5

  // the word in the flushed slot is ignored, so a skip never chains into a second skip
  always_comb begin
    op = isoops_pkg::ISOOPS_OP_NONE;
    if (insn_valid && !flush_ff) begin // RULE3
      op = isoops_decode(insn);
    end
  end

  // result steering
  always_comb begin
    result = 8'h00;
    writes_reg = 1'h0;
    writes_acc = 1'h0;
    sets_zero = 1'h0;
    nxt_flush = 1'h0;
    case (op)
      isoops_pkg::ISOOPS_OP_INC_SKIP: begin
        result = sum; // RULE1
        writes_reg = (dest == isoops_pkg::DEST_REG); // RULE2
        writes_acc = (dest == isoops_pkg::DEST_ACC); // RULE2
        nxt_flush = (sum == 8'h00); // RULE3
      end
      isoops_pkg::ISOOPS_OP_OR_LIT: begin
        result = or_lit; // RULE4
        writes_acc = 1'h1; // RULE4
        sets_zero = 1'h1; // RULE4
      end
      isoops_pkg::ISOOPS_OP_OR_REG: begin
        result = or_reg; // RULE5
        writes_reg = (dest == isoops_pkg::DEST_REG); // RULE2
        writes_acc = (dest == isoops_pkg::DEST_ACC); // RULE2
        sets_zero = 1'h1; // RULE5
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

  // accumulator holds unless an instruction routes its result there
  always_comb begin
    nxt_acc = acc_ff;
    if (writes_acc) begin
      nxt_acc = result; // RULE2
    end
  end

  // zero flag; the skip instruction leaves it alone
  always_comb begin
    nxt_zero = zero_ff; // RULE3
    if (sets_zero) begin
      nxt_zero = (result == 8'h00); // RULE6
    end
  end

  // file write-back request from the same cycle's decode
  always_comb begin
    nxt_file_we = writes_reg; // RULE2
    nxt_file_wdata = result;
    nxt_file_waddr = file_addr;
  end

  // completion for each executed word; ORs finish in their own cycle
  assign nxt_done = (op != isoops_pkg::ISOOPS_OP_NONE); // RULE6

  // accumulator
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_ff <= isoops_pkg::ACC_RESET;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // zero flag
  always_ff @(posedge clk) begin
    if (reset) begin
      zero_ff <= isoops_pkg::ZERO_RESET;
    end else begin
      zero_ff <= nxt_zero;
    end
  end

  // write strobe, registered so the write lands at the cycle's end
  always_ff @(posedge clk) begin
    if (reset) begin
      file_we_ff <= isoops_pkg::FILE_WE_RESET;
    end else begin
      file_we_ff <= nxt_file_we;
    end
  end

  // write data and address follow every cycle; only the strobe qualifies them
  always_ff @(posedge clk) begin
    if (reset) begin
      file_wdata_ff <= isoops_pkg::FILE_WDATA_RESET;
      file_waddr_ff <= isoops_pkg::FILE_WADDR_RESET;
    end else begin
      file_wdata_ff <= nxt_file_wdata;
      file_waddr_ff <= nxt_file_waddr;
    end
  end

  // flush marks the next slot as a no-operation: the skip costs one extra cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      flush_ff <= isoops_pkg::FLUSH_RESET;
    end else begin
      flush_ff <= nxt_flush; // RULE3
    end
  end

  // completion pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      done_ff <= isoops_pkg::DONE_RESET;
    end else begin
      done_ff <= nxt_done;
    end
  end
endmodule
